/* File: hw/serial_port_pkg.sv */
/*
  Package for the host serial register port: link timing, address-byte decode
  of transfer length and direction, and the general-reset command code.
  Assumes both ends and the bench import it.
*/
package serial_port_pkg;

  localparam int          CLK_MHZ          = 50;
  localparam int          SAMPLE_PERIOD_US = 250;
  localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int          SCLK_HALF_CYCLES = 4;
  localparam int          BYTE_BITS        = 8;
  localparam int          REG_COUNT        = 16;
  localparam logic [7:0]  CMD_GENERAL_RST  = 8'h01;
  // address map: 8'h00..8'h0F command (no data), 8'h10..8'h1F write one byte,
  // 8'h20..8'h2F write two bytes, 8'h30..8'h3F read one byte, 8'h40..8'h4F read two bytes
  localparam logic [3:0]  CLASS_CMD        = 4'h0;
  localparam logic [3:0]  CLASS_WR1        = 4'h1;
  localparam logic [3:0]  CLASS_WR2        = 4'h2;
  localparam logic [3:0]  CLASS_RD1        = 4'h3;
  localparam logic [3:0]  CLASS_RD2        = 4'h4;
  localparam logic [7:0]  STATUS_ADDR      = 8'h30;

  // number of data bytes that follow an address byte
  function automatic logic [1:0] data_bytes(input logic [7:0] addr);
    case (addr[7:4])
      CLASS_WR1, CLASS_RD1: data_bytes = 2'd1;
      CLASS_WR2, CLASS_RD2: data_bytes = 2'd2;
      default:              data_bytes = 2'd0;
    endcase
  endfunction : data_bytes

  function automatic logic is_read(input logic [7:0] addr);
    is_read = (addr[7:4] == CLASS_RD1) || (addr[7:4] == CLASS_RD2);
  endfunction : is_read

endpackage : serial_port_pkg

/* File: hw/serial_link_if.sv */
/*
  Four-wire serial link between the host end and the device end.
  Assumes the bench instantiates it and connects both modports.
*/
`timescale 1ns/1ps
interface serial_link_if;
  logic sclk;
  logic chip_select_n;
  logic host_command_data_in;
  logic reply_data;
  logic reply_data_oe_n;
  logic irq_n;

  modport host_end (output sclk, output chip_select_n, output host_command_data_in,
                    input reply_data, input reply_data_oe_n, input irq_n);
  modport device_end (input sclk, input chip_select_n, input host_command_data_in,
                      output reply_data, output reply_data_oe_n, output irq_n);
endinterface : serial_link_if

/* File: hw/serial_device.sv */
/*
  Device end of the host serial register port: deserialises address and data
  bytes, serves read registers, holds write registers that the core samples
  every 250 us, runs the general-reset command and drives a masked interrupt.
  Assumes a free-running i_clk far faster than the link clock; link pins are
  synchronised here.
*/
`timescale 1ns/1ps
module serial_device
  import serial_port_pkg::*;
#(
  parameter int SAMPLE_CYC = serial_port_pkg::SAMPLE_CYCLES
)(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // link
  serial_link_if.device_end link,
  // core side
  input  wire logic [7:0] i_status_lo,
  input  wire logic [7:0] i_status_hi,
  input  wire logic [7:0] i_status_event,
  output logic [15:0]     o_sampled_data [REG_COUNT],
  output logic            o_sample_tick,
  output logic            o_general_reset
);
  import serial_port_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DONE} dev_state_t;

  logic [2:0]  sclk_sync_ff, cs_sync_ff, din_sync_ff;
  logic [2:0]  nxt_sclk_sync, nxt_cs_sync, nxt_din_sync;
  dev_state_t  state_ff, nxt_state;
  logic [7:0]  shift_ff, nxt_shift, addr_ff, nxt_addr, tx_ff, nxt_tx;
  logic [2:0]  bit_ff, nxt_bit;
  logic [1:0]  left_ff, nxt_left;
  logic        first_ff, nxt_first;
  logic        rd_oe_n_ff, nxt_rd_oe_n;
  logic [15:0] wreg_ff [REG_COUNT];
  logic [15:0] nxt_wreg [REG_COUNT];
  logic [15:0] samp_ff [REG_COUNT];
  logic [15:0] nxt_samp [REG_COUNT];
  logic [7:0]  mask_ff, nxt_mask, sticky_ff, nxt_sticky;
  logic [$clog2(SAMPLE_CYC+1)-1:0] tick_ff, nxt_tick;
  logic        grst_ff, nxt_grst;
  logic        rise, fall, cs_act, cs_rise, din;

  // only the second and third stages are read by logic
  assign rise    = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign fall    = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign cs_act  = ~cs_sync_ff[1];
  assign cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
  assign din     = din_sync_ff[1];

  function automatic logic [7:0] read_byte(input logic [7:0] a, input logic second,
                                           input logic [7:0] slo, input logic [7:0] shi,
                                           input logic [7:0] stk, input logic [7:0] msk);
    if (a == STATUS_ADDR)
      read_byte = stk;
    else if (a[7:4] == CLASS_RD1)
      read_byte = msk;
    else
      read_byte = second ? slo : shi;
  endfunction : read_byte

  always_comb
  begin
    nxt_sclk_sync = {sclk_sync_ff[1:0], link.sclk};
    nxt_cs_sync   = {cs_sync_ff[1:0], link.chip_select_n};
    nxt_din_sync  = {din_sync_ff[1:0], link.host_command_data_in};
    nxt_state     = state_ff;
    nxt_shift     = shift_ff;
    nxt_addr      = addr_ff;
    nxt_tx        = tx_ff;
    nxt_bit       = bit_ff;
    nxt_left      = left_ff;
    nxt_first     = first_ff;
    nxt_rd_oe_n   = rd_oe_n_ff;
    nxt_wreg      = wreg_ff;
    nxt_samp      = samp_ff;
    nxt_mask      = mask_ff;
    nxt_grst      = 1'b0;
    nxt_sticky    = sticky_ff | i_status_event;
    nxt_tick      = tick_ff + 1'b1;
    if (tick_ff >= SAMPLE_CYC - 1)
    begin
      nxt_tick = '0;
      nxt_samp = wreg_ff;
    end
    case (state_ff)
      ST_IDLE:
      begin
        nxt_rd_oe_n = 1'b1;
        if (cs_act)
        begin
          nxt_state = ST_ADDR;
          nxt_bit   = 3'd0;
        end
      end
      ST_ADDR, ST_DATA:
      begin
        // sampling only on edges inside the frame lets the clock idle at either level
        if (rise)
        begin
          nxt_shift = {shift_ff[6:0], din};
          nxt_bit   = bit_ff + 3'd1;
          if (bit_ff == 3'd7)
          begin
            if (state_ff == ST_ADDR)
            begin
              nxt_addr  = {shift_ff[6:0], din};
              nxt_left  = data_bytes({shift_ff[6:0], din});
              nxt_first = 1'b1;
              nxt_state = (data_bytes({shift_ff[6:0], din}) == 2'd0) ? ST_DONE : ST_DATA;
              if (is_read({shift_ff[6:0], din}))
              begin
                nxt_tx = read_byte({shift_ff[6:0], din}, 1'b0, i_status_lo, i_status_hi, sticky_ff, mask_ff);
                if ({shift_ff[6:0], din} == STATUS_ADDR)
                  nxt_sticky = i_status_event;
              end
            end
            else
            begin
              nxt_left  = left_ff - 2'd1;
              nxt_first = 1'b0;
              if (!is_read(addr_ff))
              begin
                if (first_ff && left_ff == 2'd2)
                  nxt_wreg[addr_ff[3:0]][15:8] = {shift_ff[6:0], din};
                else
                  nxt_wreg[addr_ff[3:0]][7:0] = {shift_ff[6:0], din};
                if (addr_ff[7:4] == CLASS_WR1 && addr_ff[3:0] == 4'h0)
                  nxt_mask = {shift_ff[6:0], din};
              end
              if (left_ff == 2'd1)
                nxt_state = ST_DONE;
            end
            if (state_ff == ST_ADDR && {shift_ff[6:0], din} == CMD_GENERAL_RST)
              nxt_grst = 1'b1;
          end
        end
        // reply changes after the falling edge so it is settled while the clock is high
        if (fall && state_ff == ST_DATA && is_read(addr_ff))
        begin
          nxt_rd_oe_n = 1'b0;
          // the second byte is loaded only here, after a fall; the first is loaded on the rise that ends the address byte
          if (bit_ff != 3'd0)
            nxt_tx = {tx_ff[6:0], 1'b0};
          else if (!first_ff)
            nxt_tx = read_byte(addr_ff, 1'b1, i_status_lo, i_status_hi, sticky_ff, mask_ff);
        end
      end
      default:
        // hold the last reply bit through its high phase, release on the fall
        if (fall)
          nxt_rd_oe_n = 1'b1;
    endcase
    if (cs_rise)
    begin
      nxt_state   = ST_IDLE;
      nxt_bit     = 3'd0;
      nxt_rd_oe_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset || grst_ff)
    begin
      sclk_sync_ff <= '0;
      cs_sync_ff   <= 3'b111;
      din_sync_ff  <= '0;
      state_ff     <= ST_IDLE;
      shift_ff     <= '0;
      addr_ff      <= '0;
      tx_ff        <= '0;
      bit_ff       <= '0;
      left_ff      <= '0;
      first_ff     <= 1'b0;
      rd_oe_n_ff   <= 1'b1;
      wreg_ff      <= '{default: '0};
      samp_ff      <= '{default: '0};
      mask_ff      <= '0;
      sticky_ff    <= '0;
      tick_ff      <= '0;
      grst_ff      <= 1'b0;
    end
    else
    begin
      sclk_sync_ff <= nxt_sclk_sync;
      cs_sync_ff   <= nxt_cs_sync;
      din_sync_ff  <= nxt_din_sync;
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      addr_ff      <= nxt_addr;
      tx_ff        <= nxt_tx;
      bit_ff       <= nxt_bit;
      left_ff      <= nxt_left;
      first_ff     <= nxt_first;
      rd_oe_n_ff   <= nxt_rd_oe_n;
      wreg_ff      <= nxt_wreg;
      samp_ff      <= nxt_samp;
      mask_ff      <= nxt_mask;
      sticky_ff    <= nxt_sticky;
      tick_ff      <= nxt_tick;
      grst_ff      <= nxt_grst;
    end
  end

  assign link.reply_data      = tx_ff[7];
  assign link.reply_data_oe_n = rd_oe_n_ff;
  assign link.irq_n           = ~|(sticky_ff & mask_ff);
  assign o_sampled_data       = samp_ff;
  assign o_sample_tick        = (tick_ff == '0);
  assign o_general_reset      = grst_ff;

endmodule : serial_device

/* File: hw/serial_host.sv */
/*
  Host end of the host serial register port: sends one address byte and the
  number of data bytes that address implies, reading or writing them.
  Assumes a user that waits for o_ready before pulsing i_start.
*/
`timescale 1ns/1ps
module serial_host
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // user request
  input  wire logic        i_start,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ready,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic             o_irq,
  // link
  serial_link_if.host_end  link
);
  import serial_port_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;

  host_state_t state_ff, nxt_state;
  logic [23:0] out_ff, nxt_out;
  logic [15:0] in_ff, nxt_in, rdata_ff, nxt_rdata;
  logic [4:0]  bits_ff, nxt_bits;
  logic [2:0]  div_ff, nxt_div;
  logic        sclk_ff, nxt_sclk, cs_n_ff, nxt_cs_n, done_ff, nxt_done;
  logic [1:0]  irq_sync_ff, din_sync_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_out   = out_ff;
    nxt_in    = in_ff;
    nxt_rdata = rdata_ff;
    nxt_bits  = bits_ff;
    nxt_div   = div_ff + 3'd1;
    nxt_sclk  = sclk_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      H_IDLE:
      begin
        nxt_div = '0;
        if (i_start)
        begin
          nxt_state = H_SHIFT;
          nxt_cs_n  = 1'b0;
          nxt_sclk  = 1'b0;
          nxt_out   = {i_addr, (data_bytes(i_addr) == 2'd1) ? {i_wdata[7:0], 8'h00} : i_wdata};
          nxt_bits  = 5'(8 + 8 * int'(data_bytes(i_addr)));
        end
      end
      H_SHIFT:
        if (div_ff == 3'(SCLK_HALF_CYCLES - 1))
        begin
          nxt_div  = '0;
          nxt_sclk = ~sclk_ff;
          if (sclk_ff)
          begin
            // sample at the end of the high phase: the reply has crossed both sync stages by then
            nxt_in   = {in_ff[14:0], din_sync_ff[1]};
            nxt_out  = {out_ff[22:0], 1'b0};
            nxt_bits = bits_ff - 5'd1;
            if (bits_ff == 5'd1)
              nxt_state = H_GAP;
          end
        end
      H_GAP:
        if (div_ff == 3'(SCLK_HALF_CYCLES - 1))
        begin
          nxt_cs_n  = 1'b1;
          nxt_state = H_IDLE;
          nxt_done  = 1'b1;
          nxt_rdata = in_ff;
        end
      default:
        nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff    <= H_IDLE;
      out_ff      <= '0;
      in_ff       <= '0;
      rdata_ff    <= '0;
      bits_ff     <= '0;
      div_ff      <= '0;
      sclk_ff     <= 1'b0;
      cs_n_ff     <= 1'b1;
      done_ff     <= 1'b0;
      irq_sync_ff <= 2'b11;
      din_sync_ff <= '0;
    end
    else
    begin
      state_ff    <= nxt_state;
      out_ff      <= nxt_out;
      in_ff       <= nxt_in;
      rdata_ff    <= nxt_rdata;
      bits_ff     <= nxt_bits;
      div_ff      <= nxt_div;
      sclk_ff     <= nxt_sclk;
      cs_n_ff     <= nxt_cs_n;
      done_ff     <= nxt_done;
      irq_sync_ff <= {irq_sync_ff[0], link.irq_n};
      din_sync_ff <= {din_sync_ff[0], link.reply_data};
    end
  end

  assign link.sclk                 = sclk_ff;
  assign link.chip_select_n        = cs_n_ff;
  assign link.host_command_data_in = out_ff[23];
  assign o_ready                   = (state_ff == H_IDLE);
  assign o_done                    = done_ff;
  assign o_rdata                   = rdata_ff;
  assign o_irq                     = ~irq_sync_ff[1];

endmodule : serial_host

/* File: test/serial_link_asserts.sv */
/*
  Checker for the four-wire link between the host end and the device end.
  Assumes the bench feeds it the link wires and the device clock and reset.
*/
`timescale 1ns/1ps
module serial_link_asserts
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // link
  input  wire logic sclk,
  input  wire logic chip_select_n,
  input  wire logic host_command_data_in,
  input  wire logic reply_data,
  input  wire logic reply_data_oe_n,
  input  wire logic irq_n
);
  logic [5:0] rises_ff;
  logic [5:0] nxt_rises;
  logic       sclk_ff;
  logic       nxt_sclk;

  // clock rises of the current frame; cleared while deselected
  always_comb
  begin
    nxt_sclk  = sclk;
    nxt_rises = chip_select_n ? 6'h00 : rises_ff + {5'h00, sclk & ~sclk_ff};
  end

  always_ff @(posedge i_clk)
  begin
    sclk_ff  <= nxt_sclk;
    rises_ff <= i_reset ? 6'h00 : nxt_rises;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_oe_released:
    assert property (chip_select_n [*6] |-> reply_data_oe_n) else $error("reply driven while deselected");
  chk_reply_steady:
    assert property (sclk && $past(sclk) && !reply_data_oe_n && !$past(reply_data_oe_n) |-> $stable(reply_data))
    else $error("reply bit moved while clock high");
  chk_cmd_steady:
    assert property (sclk && $past(sclk) && !chip_select_n |-> $stable(host_command_data_in))
    else $error("command bit moved while clock high");
  chk_sclk_idle:
    assert property (chip_select_n [*2] |-> !sclk) else $error("link clock runs outside a frame");
  chk_sclk_half:
    assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk) else $error("link clock high phase not four cycles");
  chk_frame_start:
    assert property ($fell(chip_select_n) |-> ##[1:12] $rose(sclk)) else $error("frame opened without clocking");
  chk_whole_bytes:
    assert property ($rose(chip_select_n) |-> rises_ff inside {6'h08, 6'h10, 6'h18})
    else $error("frame not made of whole bytes");
  chk_irq_reset:
    assert property ($past(i_reset) |-> irq_n) else $error("interrupt raised out of reset");

  cover property ($rose(chip_select_n) && rises_ff == 6'h18);
  cover property (!reply_data_oe_n);
  cover property ($fell(irq_n));
endmodule : serial_link_asserts

/* File: test/host_serial_register_port_bench.sv */
/*
  Bench for the host serial register port: host end and device end on one link,
  plus a second device end whose link is driven bit by bit from here.
  Assumes the package constants and a 50 MHz clock.
*/
`timescale 1ns/1ps
module host_serial_register_port_bench;
  import serial_port_pkg::*;
  logic        i_clk          = 1'b0;
  logic        i_reset        = 1'b1;
  logic        i_start        = 1'b0;
  logic [7:0]  i_addr         = 8'h00;
  logic [15:0] i_wdata        = 16'h0000;
  logic [7:0]  i_status_lo    = 8'h5A;
  logic [7:0]  i_status_hi    = 8'hC3;
  logic [7:0]  i_status_event = 8'h00;
  logic        o_ready;
  logic        o_done;
  logic        o_irq;
  logic        o_sample_tick;
  logic        o_general_reset;
  logic        tick_b;
  logic [15:0] o_rdata;
  logic [15:0] data_a [REG_COUNT];
  logic [15:0] data_b [REG_COUNT];
  logic        drove;
  int          errors         = 0;
  int          total_checks   = 0;
  int          rises          = 0;
  int          resets         = 0;

  serial_link_if link ();
  serial_link_if link_b ();

  serial_host serial_host_inst (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .o_irq(o_irq), .link(link.host_end));
  serial_device #(.SAMPLE_CYC(50)) serial_device_inst (.i_clk(i_clk), .i_reset(i_reset), .link(link.device_end),
    .i_status_lo(i_status_lo), .i_status_hi(i_status_hi), .i_status_event(i_status_event),
    .o_sampled_data(data_a), .o_sample_tick(o_sample_tick), .o_general_reset(o_general_reset));
  serial_device #(.SAMPLE_CYC(50)) serial_device_inst_b (.i_clk(i_clk), .i_reset(i_reset), .link(link_b.device_end),
    .i_status_lo(i_status_lo), .i_status_hi(i_status_hi), .i_status_event(i_status_event),
    .o_sampled_data(data_b), .o_sample_tick(tick_b), .o_general_reset());
  serial_link_asserts serial_link_asserts_inst (.i_clk(i_clk), .i_reset(i_reset), .sclk(link.sclk),
    .chip_select_n(link.chip_select_n), .host_command_data_in(link.host_command_data_in),
    .reply_data(link.reply_data), .reply_data_oe_n(link.reply_data_oe_n), .irq_n(link.irq_n));

  initial
  begin
    // second link idles with its clock high
    link_b.sclk                 = 1'b1;
    link_b.chip_select_n        = 1'b1;
    link_b.host_command_data_in = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge link.sclk) if (!link.chip_select_n) rises++;
  // design outputs are looked at mid-cycle, where they have settled
  always @(negedge i_clk) if (o_general_reset === 1'b1) resets++;
  always @(negedge i_clk) if (link.reply_data_oe_n === 1'b0) drove = 1'b1;

  task automatic complete_run();
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cycles

  // one whole host transaction; a hang counts as a mismatch
  task automatic xfer(input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (o_ready !== 1'b1 && k < 2000)
    begin
      cycles(1);
      k++;
    end
    rises   = 0;
    drove   = 1'b0;
    i_addr  = a;
    i_wdata = d;
    i_start = 1'b1;
    cycles(1);
    i_start = 1'b0;
    while (o_done !== 1'b1 && k < 2000)
    begin
      cycles(1);
      k++;
    end
    if (k >= 2000)
    begin
      errors++;
      $display("unexpected wait for done: expected 1, seen timeout");
      complete_run();
    end
  endtask : xfer

  task automatic s_write();
    xfer(8'h25, 16'hA55A);
    check("write clock count", 16'd24, 16'(rises));
    check("reply drive on write", 16'h0000, {15'h0000, drove});
    cycles(55);
    check("two-byte register", 16'hA55A, data_a[5]);
    xfer(8'h13, 16'hFF3C);
    check("one-byte clock count", 16'd16, 16'(rises));
    cycles(55);
    check("one-byte register", 16'h003C, {8'h00, data_a[3][7:0]});
  endtask : s_write

  task automatic s_read();
    xfer(8'h40, 16'h0000);
    check("read clock count", 16'd24, 16'(rises));
    check("reply drive on read", 16'h0001, {15'h0000, drove});
    check("two-byte read", 16'hC35A, o_rdata);
  endtask : s_read

  // both sampling counters must tick once per 50-cycle period
  task automatic s_tick();
    int ta;
    int tb;
    ta = 0;
    tb = 0;
    repeat (100)
    begin
      cycles(1);
      if (o_sample_tick === 1'b1)
        ta++;
      if (tick_b === 1'b1)
        tb++;
    end
    check("sample ticks", 16'd2, 16'(ta));
    check("second sample ticks", 16'd2, 16'(tb));
  endtask : s_tick

  task automatic s_irq();
    xfer(8'h10, 16'h0001);
    cycles(55);
    i_status_event = 8'h02;
    cycles(1);
    i_status_event = 8'h00;
    cycles(20);
    check("masked interrupt", 16'h0000, {15'h0000, o_irq});
    i_status_event = 8'h01;
    cycles(1);
    i_status_event = 8'h00;
    cycles(20);
    check("unmasked interrupt", 16'h0001, {15'h0000, o_irq});
    xfer(8'h30, 16'h0000);
    check("status read", 16'h0003, {8'h00, o_rdata[7:0]});
    cycles(20);
    check("interrupt after status read", 16'h0000, {15'h0000, o_irq});
    xfer(8'h31, 16'h0000);
    check("mask read", 16'h0001, {8'h00, o_rdata[7:0]});
  endtask : s_irq

  task automatic bb_bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      link_b.sclk                 = 1'b0;
      link_b.host_command_data_in = v[i];
      cycles(4);
      link_b.sclk                 = 1'b1;
      cycles(4);
    end
  endtask : bb_bits

  // partial byte, then a framed write with a long gap between bytes
  task automatic s_abandon();
    link_b.chip_select_n = 1'b0;
    cycles(4);
    bb_bits(8'hFF, 5);
    link_b.chip_select_n = 1'b1;
    cycles(8);
    link_b.chip_select_n = 1'b0;
    cycles(4);
    bb_bits(8'h2A, 8);
    cycles(40);
    bb_bits(8'h12, 8);
    bb_bits(8'h34, 8);
    cycles(4);
    link_b.chip_select_n        = 1'b1;
    link_b.host_command_data_in = ~link_b.host_command_data_in;
    cycles(55);
    check("register after abandoned byte", 16'h1234, data_b[10]);
  endtask : s_abandon

  task automatic s_command();
    for (int a = 0; a < 4; a++)
    begin
      resets = 0;
      xfer(8'(a), 16'hFFFF);
      cycles(5);
      check("command clock count", 16'd8, 16'(rises));
      check("general reset pulses", (a == 1) ? 16'h0001 : 16'h0000, 16'(resets));
    end
  endtask : s_command

  initial
  begin
    repeat (6) @(posedge i_clk);
    cycles(1);
    i_reset = 1'b0;
    s_write();
    s_read();
    s_irq();
    s_abandon();
    s_tick();
    s_command();
    complete_run();
  end
endmodule : host_serial_register_port_bench
